/* File: verilog/twoc_map.svh */
`ifndef TWOC_MAP_SVH
`define TWOC_MAP_SVH
// Summary of operation
// [R1] Nonzero output mode connects wave to pin, except toggle in PWM modes without toggle.
// [R2] Pin driver enabled only by direction bit.
// [R3] Non-PWM: disconnect, toggle, clear, set on match.
// [R4] Fast PWM: clear/set on match, opposite at bottom.
// [R5] Fast PWM toggle: channel A, mode 15 only.
// [R6] Fast PWM: compare equal top ignores match.
// [R7] Dual-slope: match action depends on count direction.
// [R8] Dual-slope toggle: channel A, mode 9 only.
// [R9] Force strobes act only in non-PWM modes.
// [R10] Software writes force bits zero in PWM.
// [R11] Force strobe applies match using current mode.
// [R12] Force raises no flag, never clears counter.
// [R13] Force bits always read back as zero.
// [R14] Four-bit waveform mode split; code 13 reserved.
// [R15] Normal and clear-on-match tops, update, overflow.
// [R16] Phase correct tops; update top, overflow bottom.
// [R17] Fast PWM tops; update bottom, overflow top.
// [R18] Frequency correct: update and overflow at bottom.
// [R19] Dual-slope: compare at bottom/top holds level.
// [R20] Mode 9 toggle gives square wave.
// [R21] Events other than force strobes evaluated only on timer clock enable.
`define TWOC_OFF_CTRL_A  8'h00
`define TWOC_OFF_CTRL_B  8'h04
`define TWOC_OFF_CMP_A   8'h08
`define TWOC_OFF_CMP_B   8'h0c
`define TWOC_OFF_CAP     8'h10
`define TWOC_OFF_PORT    8'h14
`define TWOC_OFF_STAT    8'h18
`define TWOC_COM_A_LSB   6
`define TWOC_COM_B_LSB   4
`define TWOC_FORCE_A_BIT 3
`define TWOC_FORCE_B_BIT 2
`define TWOC_WGM_LO_LSB  0
`define TWOC_WGM_HI_LSB  3
`define TWOC_PDIR_LSB    0
`define TWOC_PVAL_LSB    2
`define TWOC_STAT_OVF    16
`define TWOC_STAT_UP     17
`define TWOC_RST_16      16'h0000
`define TWOC_TOP_MAX     16'hffff
`define TWOC_TOP_8       16'h00ff
`define TWOC_TOP_9       16'h01ff
`define TWOC_TOP_10      16'h03ff
`define TWOC_WGM_NORMAL  4'h0
`define TWOC_WGM_RSVD    4'hd
`define TWOC_WGM_PFC_A   4'h9
`define TWOC_WGM_FAST_I  4'he
`define TWOC_WGM_FAST_A  4'hf
`define TWOC_RESP_OKAY   2'b00
`define TWOC_RESP_SLVERR 2'b10
`endif

/* File: verilog/twoc_pkg.sv */
`include "twoc_map.svh"
package twoc_pkg;
  typedef enum logic [1:0] {
    TWOC_NONPWM = 2'b00,
    TWOC_FAST   = 2'b01,
    TWOC_DUAL   = 2'b10,
    TWOC_RSVD   = 2'b11
  } twoc_cls_e;

  typedef struct packed {
    logic out_a;
    logic oe_a;
    logic out_b;
    logic oe_b;
  } twoc_pins_s;

  function automatic twoc_cls_e twoc_cls_of(input logic [3:0] wgm);
    unique case (wgm)
      4'h0, 4'h4, 4'hc:             twoc_cls_of = TWOC_NONPWM;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: twoc_cls_of = TWOC_FAST;
      4'hd:                         twoc_cls_of = TWOC_RSVD;
      default:                      twoc_cls_of = TWOC_DUAL;
    endcase
  endfunction

  function automatic logic [15:0] twoc_top_of(input logic [3:0] wgm, input logic [15:0] cmp_a,
                                              input logic [15:0] cap);
    unique case (wgm)
      4'h1, 4'h5:             twoc_top_of = `TWOC_TOP_8;
      4'h2, 4'h6:             twoc_top_of = `TWOC_TOP_9;
      4'h3, 4'h7:             twoc_top_of = `TWOC_TOP_10;
      4'h4, 4'h9, 4'hb, 4'hf: twoc_top_of = cmp_a;
      4'h8, 4'ha, 4'hc, 4'he: twoc_top_of = cap;
      default:                twoc_top_of = `TWOC_TOP_MAX;
    endcase
  endfunction
endpackage

/* File: verilog/twoc_wave_unit.sv */
`timescale 1ns/1ps
`include "twoc_map.svh"
module twoc_wave_unit #(
  parameter bit CH_A = 1'b1
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                tick,
  input  wire logic                force_match,
  input  wire logic                match,
  input  wire logic                at_bottom,
  input  wire logic                cmp_top,
  input  wire logic                cmp_zero,
  input  wire logic                count_up,
  input  twoc_pkg::twoc_cls_e      cls,
  input  wire logic [3:0]          waveform_mode,
  input  wire logic [1:0]          out_mode,
  output logic                     wave,
  output logic                     conn
);
  import twoc_pkg::*;

  typedef struct packed {
    logic wave;
    logic conn;
  } twoc_unit_s;

  twoc_unit_s s_q;
  twoc_unit_s s_d;
  logic       tog_ok;

  function automatic logic twoc_nonpwm_act(input logic [1:0] com, input logic w);
    unique case (com)
      2'b01:   twoc_nonpwm_act = ~w;
      2'b10:   twoc_nonpwm_act = 1'b0;
      2'b11:   twoc_nonpwm_act = 1'b1;
      default: twoc_nonpwm_act = w;
    endcase
  endfunction

  always_comb
  begin
    s_d    = s_q;
    tog_ok = CH_A && ((cls == TWOC_FAST && waveform_mode == `TWOC_WGM_FAST_A) ||              // R5
             (cls == TWOC_DUAL && (waveform_mode == `TWOC_WGM_PFC_A ||
                                   waveform_mode == `TWOC_WGM_FAST_I)));                     // R8 R20
    s_d.conn = (out_mode != 2'b00) && (out_mode != 2'b01 || cls == TWOC_NONPWM || tog_ok);   // R1
    if (force_match && cls == TWOC_NONPWM)
    begin
      s_d.wave = twoc_nonpwm_act(out_mode, s_q.wave);                                        // R11
    end
    else if (tick)                                                                           // R21
    begin
      unique case (cls)
        TWOC_NONPWM:
        begin
          if (match)
          begin
            s_d.wave = twoc_nonpwm_act(out_mode, s_q.wave);                                  // R3
          end
        end
        TWOC_FAST:
        begin
          if (out_mode == 2'b01 && tog_ok && match)
          begin
            s_d.wave = ~s_q.wave;                                                            // R5
          end
          if (out_mode[1])
          begin
            if (at_bottom)
            begin
              s_d.wave = ~out_mode[0];                                                       // R4
            end
            if (match && !cmp_top)
            begin
              s_d.wave = out_mode[0];                                                        // R4 R6
            end
          end
        end
        TWOC_DUAL:
        begin
          if (out_mode == 2'b01 && tog_ok && match)
          begin
            s_d.wave = ~s_q.wave;                                                            // R8 R20
          end
          if (out_mode[1])
          begin
            if (cmp_zero)
            begin
              s_d.wave = out_mode[0];                                                        // R19
            end
            else if (cmp_top)
            begin
              s_d.wave = ~out_mode[0];                                                       // R19
            end
            else if (match)
            begin
              s_d.wave = ~count_up ^ out_mode[0];                                            // R7
            end
          end
        end
        TWOC_RSVD:
        begin
          s_d.wave = s_q.wave;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wave = s_q.wave;
  assign conn = s_q.conn;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_nonpwm_clear;
    (tick && !force_match && cls == TWOC_NONPWM && out_mode == 2'b10 && match) |=> !wave;
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("non-PWM clear on match failed"); // R3

  property p_fast_bottom;
    (tick && cls == TWOC_FAST && out_mode == 2'b10 && at_bottom && !match) |=> wave;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast PWM set at bottom failed"); // R4

  property p_dual_zero;
    (tick && cls == TWOC_DUAL && out_mode == 2'b11 && cmp_zero) |=> wave;
  endproperty
  a_dual_zero: assert property (p_dual_zero) else $error("inverted dual-slope bottom level wrong"); // R19
endmodule

/* File: verilog/twoc_top.sv */
`timescale 1ns/1ps
`include "twoc_map.svh"
module twoc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                tmr_clk_en,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  output twoc_pkg::twoc_pins_s     pins
);
  import twoc_pkg::*;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic              arready;
    logic              rvalid;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        com_a;
    logic [1:0]        com_b;
    logic [1:0]        wgm_lo;
    logic [1:0]        wgm_hi;
    logic [1:0]        force_m;
    logic [1:0]        pdir;
    logic [1:0]        pval;
    logic [15:0]       cnt;
    logic              up;
    logic              ovf;
    logic [15:0]       cmp_a;
    logic [15:0]       cmp_a_buf;
    logic [15:0]       cmp_b;
    logic [15:0]       cmp_b_buf;
    logic [15:0]       cap;
    twoc_pins_s        pins;
  } twoc_state_s;

  twoc_state_s st_q;
  twoc_state_s st_d;
  logic [3:0]  wgm;
  twoc_cls_e   cls;
  logic [15:0] top_v;
  logic        wave_a;
  logic        wave_b;
  logic        conn_a;
  logic        conn_b;
  logic        wr_go;
  logic [3:0]  wgm_new;

  function automatic logic [15:0] twoc_merge16(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
    twoc_merge16 = old;
    if (strb[0])
    begin
      twoc_merge16[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      twoc_merge16[15:8] = data[15:8];
    end
  endfunction

  function automatic logic twoc_is_pc(input logic [3:0] w);
    twoc_is_pc = (w == 4'h1) || (w == 4'h2) || (w == 4'h3) || (w == 4'ha) || (w == 4'hb);
  endfunction

  assign wgm   = {st_q.wgm_hi, st_q.wgm_lo};                                                 // R14
  assign cls   = twoc_cls_of(wgm);
  assign top_v = twoc_top_of(wgm, st_q.cmp_a, st_q.cap);
  assign wr_go = !st_q.awready && !st_q.wready && !st_q.bvalid;

  always_comb
  begin
    st_d       = st_q;
    wgm_new    = wgm;
    st_d.force_m = 2'b00;
    if (awvalid && st_q.awready)
    begin
      st_d.awready = 1'b0;
      st_d.awaddr  = awaddr;
    end
    if (wvalid && st_q.wready)
    begin
      st_d.wready = 1'b0;
      st_d.wdata  = wdata;
      st_d.wstrb  = wstrb;
    end
    if (wr_go)
    begin
      st_d.bvalid = 1'b1;
      st_d.bresp  = `TWOC_RESP_OKAY;
      unique case (st_q.awaddr)
        `TWOC_OFF_CTRL_A:
        begin
          if (st_q.wstrb[0])
          begin
            st_d.com_a  = st_q.wdata[`TWOC_COM_A_LSB +: 2];
            st_d.com_b  = st_q.wdata[`TWOC_COM_B_LSB +: 2];
            st_d.wgm_lo = st_q.wdata[`TWOC_WGM_LO_LSB +: 2];
            wgm_new     = {st_q.wgm_hi, st_q.wdata[`TWOC_WGM_LO_LSB +: 2]};
            // The strobes are not stored, so a stray one in a PWM mode leaves no trace.
            if (twoc_cls_of(wgm_new) == TWOC_NONPWM)                                          // R9 R10
            begin
              st_d.force_m = {st_q.wdata[`TWOC_FORCE_A_BIT], st_q.wdata[`TWOC_FORCE_B_BIT]};  // R11
            end
          end
        end
        `TWOC_OFF_CTRL_B:
        begin
          if (st_q.wstrb[0])
          begin
            st_d.wgm_hi = st_q.wdata[`TWOC_WGM_HI_LSB +: 2];                                  // R14
          end
        end
        `TWOC_OFF_CMP_A:
        begin
          st_d.cmp_a_buf = twoc_merge16(st_q.cmp_a_buf, st_q.wdata, st_q.wstrb);
          if (cls == TWOC_NONPWM)
          begin
            st_d.cmp_a = twoc_merge16(st_q.cmp_a_buf, st_q.wdata, st_q.wstrb);               // R15
          end
        end
        `TWOC_OFF_CMP_B:
        begin
          st_d.cmp_b_buf = twoc_merge16(st_q.cmp_b_buf, st_q.wdata, st_q.wstrb);
          if (cls == TWOC_NONPWM)
          begin
            st_d.cmp_b = twoc_merge16(st_q.cmp_b_buf, st_q.wdata, st_q.wstrb);               // R15
          end
        end
        `TWOC_OFF_CAP:
        begin
          st_d.cap = twoc_merge16(st_q.cap, st_q.wdata, st_q.wstrb);
        end
        `TWOC_OFF_PORT:
        begin
          if (st_q.wstrb[0])
          begin
            st_d.pdir = st_q.wdata[`TWOC_PDIR_LSB +: 2];
            st_d.pval = st_q.wdata[`TWOC_PVAL_LSB +: 2];
          end
        end
        `TWOC_OFF_STAT:
        begin
          if (st_q.wstrb[2] && st_q.wdata[`TWOC_STAT_OVF])
          begin
            st_d.ovf = 1'b0;
          end
        end
        default:
        begin
          st_d.bresp = `TWOC_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && bready)
    begin
      st_d.bvalid  = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end
    if (arvalid && st_q.arready)
    begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = `TWOC_RESP_OKAY;
      unique case (araddr)
        `TWOC_OFF_CTRL_A: st_d.rdata = {24'h00_0000, st_q.com_a, st_q.com_b, 2'b00, st_q.wgm_lo}; // R13
        `TWOC_OFF_CTRL_B: st_d.rdata = {27'h000_0000, st_q.wgm_hi, 3'h0};
        `TWOC_OFF_CMP_A:  st_d.rdata = {16'h0000, st_q.cmp_a_buf};
        `TWOC_OFF_CMP_B:  st_d.rdata = {16'h0000, st_q.cmp_b_buf};
        `TWOC_OFF_CAP:    st_d.rdata = {16'h0000, st_q.cap};
        `TWOC_OFF_PORT:   st_d.rdata = {28'h000_0000, st_q.pval, st_q.pdir};
        `TWOC_OFF_STAT:   st_d.rdata = {14'h0000, st_q.up, st_q.ovf, st_q.cnt};
        default:
        begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = `TWOC_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && rready)
    begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
    // The counter step follows the register write so that a flag set wins over its clear.
    if (tmr_clk_en)                                                                          // R21
    begin
      unique case (cls)
        TWOC_NONPWM:
        begin
          // A forced compare never reaches this branch, so it cannot clear the counter.
          if (wgm != `TWOC_WGM_NORMAL && st_q.cnt == top_v)                                  // R12
          begin
            st_d.cnt = `TWOC_RST_16;                                                         // R15
          end
          else
          begin
            st_d.cnt = st_q.cnt + 16'h0001;
          end
          if (st_q.cnt == `TWOC_TOP_MAX)
          begin
            st_d.ovf = 1'b1;                                                                 // R15
          end
        end
        TWOC_FAST:
        begin
          if (st_q.cnt == top_v)
          begin
            st_d.cnt   = `TWOC_RST_16;
            st_d.ovf   = 1'b1;                                                               // R17
            st_d.cmp_a = st_q.cmp_a_buf;                                                     // R17
            st_d.cmp_b = st_q.cmp_b_buf;
          end
          else
          begin
            st_d.cnt = st_q.cnt + 16'h0001;
          end
        end
        TWOC_DUAL:
        begin
          if (st_q.up)
          begin
            if (st_q.cnt >= top_v)
            begin
              st_d.up  = 1'b0;
              st_d.cnt = st_q.cnt - 16'h0001;
              if (twoc_is_pc(wgm))
              begin
                st_d.cmp_a = st_q.cmp_a_buf;                                                 // R16
                st_d.cmp_b = st_q.cmp_b_buf;
              end
            end
            else
            begin
              st_d.cnt = st_q.cnt + 16'h0001;
            end
          end
          else if (st_q.cnt == `TWOC_RST_16)
          begin
            st_d.up  = 1'b1;
            st_d.cnt = st_q.cnt + 16'h0001;
            st_d.ovf = 1'b1;                                                                 // R16 R18
            if (!twoc_is_pc(wgm))
            begin
              st_d.cmp_a = st_q.cmp_a_buf;                                                   // R18
              st_d.cmp_b = st_q.cmp_b_buf;
            end
          end
          else
          begin
            st_d.cnt = st_q.cnt - 16'h0001;
          end
        end
        TWOC_RSVD:
        begin
          st_d.cnt = st_q.cnt;                                                               // R14
        end
      endcase
    end
    st_d.pins.out_a = conn_a ? wave_a : st_q.pval[0];                                        // R1
    st_d.pins.out_b = conn_b ? wave_b : st_q.pval[1];                                        // R1
    st_d.pins.oe_a  = st_q.pdir[0];                                                          // R2
    st_d.pins.oe_b  = st_q.pdir[1];                                                          // R2
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q         <= '0;
      st_q.awready <= 1'b1;
      st_q.wready  <= 1'b1;
      st_q.arready <= 1'b1;
      st_q.up      <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  twoc_wave_unit #(
    .CH_A (1'b1)
  ) u_wave_a (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .tick          (tmr_clk_en),
    .force_match   (st_q.force_m[1]),
    .match         (st_q.cnt == st_q.cmp_a),
    .at_bottom     (st_q.cnt == `TWOC_RST_16),
    .cmp_top       (st_q.cmp_a == top_v),
    .cmp_zero      (st_q.cmp_a == `TWOC_RST_16),
    .count_up      (st_q.up),
    .cls           (cls),
    .waveform_mode (wgm),
    .out_mode      (st_q.com_a),
    .wave          (wave_a),
    .conn          (conn_a)
  );

  twoc_wave_unit #(
    .CH_A (1'b0)
  ) u_wave_b (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .tick          (tmr_clk_en),
    .force_match   (st_q.force_m[0]),
    .match         (st_q.cnt == st_q.cmp_b),
    .at_bottom     (st_q.cnt == `TWOC_RST_16),
    .cmp_top       (st_q.cmp_b == top_v),
    .cmp_zero      (st_q.cmp_b == `TWOC_RST_16),
    .count_up      (st_q.up),
    .cls           (cls),
    .waveform_mode (wgm),
    .out_mode      (st_q.com_b),
    .wave          (wave_b),
    .conn          (conn_b)
  );

  assign awready = st_q.awready;
  assign wready  = st_q.wready;
  assign bvalid  = st_q.bvalid;
  assign bresp   = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid  = st_q.rvalid;
  assign rdata   = st_q.rdata;
  assign rresp   = st_q.rresp;
  assign pins    = st_q.pins;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_com_a_off;
    (st_q.com_a == 2'b00) ##1 (st_q.com_a == 2'b00);
  endsequence

  property p_port_restore;
    s_com_a_off |=> (pins.out_a == $past(st_q.pval[0]));
  endproperty
  a_port_restore: assert property (p_port_restore) else $error("pin A not returned to port value"); // R1

  property p_oe_dir;
    !st_q.pdir[0] |=> !pins.oe_a;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("pin A driven without direction bit"); // R2

  property p_force_nonpwm;
    (st_q.force_m != 2'b00) |-> (cls == TWOC_NONPWM);
  endproperty
  a_force_nonpwm: assert property (p_force_nonpwm) else $error("force strobe in PWM mode"); // R9

  property p_force_cnt;
    (st_q.force_m != 2'b00 && !tmr_clk_en) |=> $stable(st_q.cnt) && $stable(st_q.ovf);
  endproperty
  a_force_cnt: assert property (p_force_cnt) else $error("force strobe altered counter or flag"); // R12

  property p_force_read;
    (arvalid && arready && araddr == `TWOC_OFF_CTRL_A) |=> (rdata[3:2] == 2'b00);
  endproperty
  a_force_read: assert property (p_force_read) else $error("force bits read as nonzero"); // R13

  property p_rsvd_hold;
    (tmr_clk_en && wgm == `TWOC_WGM_RSVD) |=> $stable(st_q.cnt);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("counter moved in reserved mode"); // R14

  property p_normal_wrap;
    (tmr_clk_en && wgm == `TWOC_WGM_NORMAL && st_q.cnt == `TWOC_TOP_MAX) |=> (st_q.cnt == 16'h0000 && st_q.ovf);
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal mode wrap or overflow wrong"); // R15

  property p_pc_update;
    (tmr_clk_en && twoc_is_pc(wgm) && st_q.up && st_q.cnt >= top_v) |=> (st_q.cmp_a == $past(st_q.cmp_a_buf));
  endproperty
  a_pc_update: assert property (p_pc_update) else $error("phase correct update not at top"); // R16

  property p_fast_top;
    (tmr_clk_en && cls == TWOC_FAST && st_q.cnt == top_v) |=> (st_q.cnt == 16'h0000 && st_q.ovf);
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast PWM wrap or overflow wrong"); // R17

  property p_pfc_bottom;
    (tmr_clk_en && cls == TWOC_DUAL && !twoc_is_pc(wgm) && !st_q.up && st_q.cnt == 16'h0000)
      |=> (st_q.cmp_a == $past(st_q.cmp_a_buf) && st_q.ovf);
  endproperty
  a_pfc_bottom: assert property (p_pfc_bottom) else $error("frequency correct bottom event wrong"); // R18
endmodule

/* File: dv/twoc_tb.sv */
`timescale 1ns/1ps
module testbench;
  import twoc_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic        tmr_clk_en;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  twoc_pins_s  pins;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  int          w, p, c, k;

  twoc_top twoc_top_i (.aclk(aclk), .aresetn(aresetn), .tmr_clk_en(tmr_clk_en), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .pins(pins));

  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
      begin
        fails++;
        $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rdr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Pin A shows the wave when connected, else the port value, which differs from the wave.
  task setm(input logic [7:0] b, input logic [7:0] a, input int conn);
    wr(8'h04, {24'h0000_00, b});
    wr(8'h00, {24'h0000_00, a});
    repeat (3) @(posedge aclk);
    chk(32'(pins.out_a), conn ? w : p);
  endtask

  initial
  begin
    {tmr_clk_en, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb   = 4'hf;
    aresetn = 1'b0;
    void'($urandom(2919));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(8'h00);
    chk(rd, 32'h0000_0000);
    rdr(8'h1c);
    chk(32'(rs), 32'h0000_0002);
    wr(8'h1c, $urandom);
    chk(32'(rs), 32'h0000_0002);
    p = 1;
    wr(8'h14, 32'h0000_000f);
    repeat (3) @(posedge aclk);
    chk(32'(pins), 32'h0000_000f);
    $display("test registers done");
    w = 0;
    // The timer clock stays off, so only the strobes can move the wave.
    for (int i = 0; i < 4; i++)
    begin
      c = (i == 0) ? 3 : ((i == 3) ? 2 : 1);
      w = (c == 1) ? 1 - w : c - 2;
      setm(8'h00, {c[1:0], 6'b00_1000}, 1);
    end
    rdr(8'h00);
    chk(rd, {24'h0000_00, c[1:0], 6'h00});
    $display("test force done");
    setm(8'h08, 8'h41, 0);
    setm(8'h18, 8'h43, 1);
    setm(8'h18, 8'hcb, 1);
    setm(8'h10, 8'h40, 0);
    setm(8'h10, 8'h41, 1);
    $display("test modes done");
    setm(8'h00, 8'h40, 1);
    c = $urandom_range(50, 1);
    k = c + $urandom_range(20, 1);
    wr(8'h08, 32'(c));
    tmr_clk_en <= 1'b1;
    repeat (k) @(posedge aclk);
    tmr_clk_en <= 1'b0;
    repeat (3) @(posedge aclk);
    rdr(8'h18);
    chk(32'(rd[15:0]), k);
    w = 1 - w;
    chk(32'(pins.out_a), w);
    $display("test count done");
    c = $urandom_range(20, 1);
    k = c + $urandom_range(10, 1);
    setm(8'h08, 8'h81, 1);
    wr(8'h08, 32'(c));
    tmr_clk_en <= 1'b1;
    // Runs from the old count through one wrap at the 8-bit top, then k ticks more.
    repeat (256 + k - int'(rd[15:0])) @(posedge aclk);
    tmr_clk_en <= 1'b0;
    rdr(8'h18);
    chk(32'(rd[16:0]), 32'h0001_0000 + k);
    w = 0;
    chk(32'(pins.out_a), w);
    $display("test fast done");
    setm(8'h00, 8'hc1, 1);
    wr(8'h08, 32'h0000_0000);
    tmr_clk_en <= 1'b1;
    repeat (256) @(posedge aclk);
    tmr_clk_en <= 1'b0;
    rdr(8'h18);
    chk(32'(rd[17:0]), 32'h0001_00fe - k);
    chk(32'(pins.out_a), 1);
    $display("test dual done");
    report_and_stop();
  end
endmodule
